// File: core/timer_pkg.sv
package timer_pkg;

	// register byte addresses
	localparam logic [7:0] OFF_MODE     = 8'hf1;
	localparam logic [7:0] OFF_COUNT    = 8'hf2;
	localparam logic [7:0] OFF_PRESCALE = 8'hf3;
	localparam logic [7:0] OFF_CTL_BASE = 8'he0;
	localparam logic [7:0] OFF_CTL_A    = 8'he1;
	localparam logic [7:0] OFF_LOW      = 8'he2;
	localparam logic [7:0] OFF_HIGH     = 8'he3;
	localparam logic [7:0] OFF_RISE     = 8'he4;
	localparam logic [7:0] OFF_FALL     = 8'he5;

	// timer_mode_control fields
	localparam int MODE_SEL_LO = 6;
	localparam int MODE_EN     = 3;
	localparam int MODE_LOAD   = 2;
	localparam logic [1:0] TOUT_SEL_GEN   = 2'h2;
	localparam logic [1:0] MODE_RSVD_READ = 2'h3;

	// general_timer_prescale fields
	localparam int PRE_MOD_LO = 2;
	localparam int PRE_SRC    = 1;
	localparam int PRE_CONT   = 0;

	// pulse_control_a fields
	localparam int CA_DEMOD   = 7;
	localparam int CA_FALL_EN = 5;
	localparam int CA_RISE_EN = 4;
	localparam int CA_INIT    = 1;
	localparam int CA_RISE_ST = 1;
	localparam int CA_FALL_ST = 0;

	// pulse_control_base fields
	localparam int CB_EN      = 7;
	localparam int CB_MODN    = 6;
	localparam int CB_TO_ST   = 5;
	localparam int CB_EDGE_IE = 2;
	localparam int CB_TO_IE   = 1;

	// reset values and counts
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [7:0] ALL_ONES   = 8'hff;
	localparam int CRYSTAL_PER_TICK   = 8;
	localparam logic [2:0] TICK_LAST  = 3'(CRYSTAL_PER_TICK - 1);

	typedef enum logic [4:0] {
		PT_IDLE  = 5'b00001,
		PT_TX    = 5'b00010,
		PT_DONE  = 5'b00100,
		PT_WAIT  = 5'b01000,
		PT_COUNT = 5'b10000
	} pulse_state_t;

endpackage : timer_pkg

// File: core/edge_sync.sv
`timescale 1ns/1ns
`default_nettype none

module edge_sync (
	// clock and reset
	input  wire logic ref_clk,
	input  wire logic rstn,
	// pin side
	input  wire logic pinIn,
	// single-cycle edge pulses
	output logic      risePulse,
	output logic      fallPulse
);

	logic meta_r;
	logic sync_r;
	logic last_r;

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
			last_r <= 1'b0;
		end else begin
			meta_r <= pinIn;
			sync_r <= meta_r;
			last_r <= sync_r;
		end
	end

	assign risePulse = sync_r & ~last_r;
	assign fallPulse = ~sync_r & last_r;

	a_edge_single: assert property (@(posedge ref_clk) disable iff (!rstn)
		risePulse |=> !risePulse) else $error("edge pulse longer than one cycle");

endmodule : edge_sync

`default_nettype wire

// File: core/pulse_timer_block.sv
// The address-and-strobe port was decided locally.
`timescale 1ns/1ns
`default_nettype none

// Operation
// - 8-bit down counter behind its own 6-bit prescaler, free of software timing.
// - at end-of-count stop in single-pass, reload and continue in continuous mode.
// - new count taken immediately on load, else at next end-of-count in continuous mode.
// - count and prescaler registers writable while the timer runs.
// - prescaler bits 7..2 hold the modulo, up to 64; low bits control.
// - prescaler bit 1 internal/external clock, bit 0 continuous/single-pass.
// - write-only initial count and read-only live count share one address.
// - initial count 1 to 256, zero meaning 256.
// - mode bits load and enable-count start and stop the general timer.
// - interval is eight crystal periods times prescaler times count.
// - mode bits 7,6 = 1,0 route toggle output; 0,0 returns port data.
// - writing 1 to the load bit forces the toggle output high.
// - each end-of-count raises an interrupt and inverts the toggle output.
// - before transmit enable, pulse output is inverse of initial-output bit; once a single pass ends it holds its last level.
// - on transmit enable output takes initial value; load low or high register.
// - single-pass transmit counts to zero, stops, toggles, sets time-out, optional interrupt.
// - modulo-N transmit toggles at zero, reloads low if output 0 else high.
// - demodulation needs all-ones loads; counting starts at first selected edge.
// - later selected edge captures inverted count, sets edge status, reloads high.
// - zero during demodulation sets time-out, optional interrupt, continues from all ones.
module pulse_timer_block (
	// clock and reset
	input  wire logic       ref_clk,
	input  wire logic       rstn,
	// register port
	input  wire logic [7:0] addr,
	input  wire logic [7:0] wrData,
	input  wire logic       wrEn,
	input  wire logic       rdEn,
	output logic      [7:0] rdData,
	// pins
	input  wire logic       timerInPin,
	input  wire logic       pulseInPin,
	input  wire logic       port5DataBit,
	output logic            port5Bit6Pin,
	output logic            pulseTimerOutput,
	// interrupt requests
	output logic            generalTimerIrq,
	output logic            pulseTimerIrq
);

	// base tick: one timer clock per eight crystal periods
	logic [2:0] tickCnt_r;
	logic       baseTick;

	always_ff @(posedge ref_clk) begin
		if (!rstn)
			tickCnt_r <= 3'h0;
		else
			tickCnt_r <= baseTick ? 3'h0 : tickCnt_r + 3'h1;
	end

	assign baseTick = (tickCnt_r == timer_pkg::TICK_LAST);

	// synchronised pin edges
	logic extRise;
	logic pinRise;
	logic pinFall;

	edge_sync u_timer_in (
		.ref_clk   (ref_clk),
		.rstn      (rstn),
		.pinIn     (timerInPin),
		.risePulse (extRise),
		.fallPulse ()
	);

	edge_sync u_pulse_in (
		.ref_clk   (ref_clk),
		.rstn      (rstn),
		.pinIn     (pulseInPin),
		.risePulse (pinRise),
		.fallPulse (pinFall)
	);

	// address decode
	wire wrMode  = wrEn && (addr == timer_pkg::OFF_MODE);
	wire wrCount = wrEn && (addr == timer_pkg::OFF_COUNT);
	wire wrPre   = wrEn && (addr == timer_pkg::OFF_PRESCALE);
	wire wrBase  = wrEn && (addr == timer_pkg::OFF_CTL_BASE);
	wire wrCtlA  = wrEn && (addr == timer_pkg::OFF_CTL_A);
	wire wrLow   = wrEn && (addr == timer_pkg::OFF_LOW);
	wire wrHigh  = wrEn && (addr == timer_pkg::OFF_HIGH);

	// ---------------- general timer ----------------
	logic [1:0] modeSel_r;
	logic       genEnable_r;
	logic [7:0] initVal_r;
	logic [7:0] prescale_r;
	logic [5:0] preCnt_r;
	logic [7:0] genCnt_r;
	logic       toggle_r;
	logic       genIrq_r;
	logic       pin_r;

	wire [5:0] modulo    = prescale_r[7:timer_pkg::PRE_MOD_LO];
	wire       contMode  = prescale_r[timer_pkg::PRE_CONT];
	wire       srcTick   = prescale_r[timer_pkg::PRE_SRC] ? baseTick : extRise;
	wire       loadPulse = wrMode && wrData[timer_pkg::MODE_LOAD];
	wire       preTick   = genEnable_r && srcTick && (preCnt_r == 6'h01);
	// zero modulo wraps through 63 and so divides by 64
	wire       genEoc    = preTick && (genCnt_r == 8'h01);
	wire       genEnable_nxt = wrMode ? wrData[timer_pkg::MODE_EN] :
		(genEoc && !contMode) ? 1'b0 : genEnable_r;

	wire [5:0] preCnt_nxt = loadPulse ? modulo :
		(genEnable_r && srcTick) ? (preTick ? modulo : preCnt_r - 6'h01) : preCnt_r;

	// pending initial value reaches the counter only by load or reload
	wire [7:0] genCnt_nxt = loadPulse ? initVal_r :
		(genEoc && contMode) ? initVal_r :
		preTick ? genCnt_r - 8'h01 : genCnt_r;

	wire toggle_nxt = loadPulse ? 1'b1 : genEoc ? ~toggle_r : toggle_r;

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			modeSel_r   <= 2'h0;
			genEnable_r <= 1'b0;
			initVal_r   <= timer_pkg::RESET_BYTE;
			prescale_r  <= timer_pkg::RESET_BYTE;
		end else begin
			if (wrMode)
				modeSel_r <= wrData[7:timer_pkg::MODE_SEL_LO];
			genEnable_r <= genEnable_nxt;
			if (wrCount)
				initVal_r <= wrData;
			if (wrPre)
				prescale_r <= wrData;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			preCnt_r <= 6'h00;
			genCnt_r <= timer_pkg::RESET_BYTE;
			toggle_r <= 1'b1;
			genIrq_r <= 1'b0;
			pin_r    <= 1'b0;
		end else begin
			preCnt_r <= preCnt_nxt;
			genCnt_r <= genCnt_nxt;
			toggle_r <= toggle_nxt;
			genIrq_r <= genEoc;
			pin_r    <= (modeSel_r == timer_pkg::TOUT_SEL_GEN) ? toggle_r : port5DataBit;
		end
	end

	// ---------------- pulse timer ----------------
	timer_pkg::pulse_state_t state_r;
	timer_pkg::pulse_state_t state_nxt;
	logic [7:0] ctlA_r;
	logic [7:0] ctlB_r;
	logic [7:0] lowLoad_r;
	logic [7:0] highLoad_r;
	logic [7:0] riseCap_r;
	logic [7:0] fallCap_r;
	logic [7:0] ptCnt_r;
	logic [7:0] ptCnt_nxt;
	logic       ptOut_r;
	logic       ptOut_nxt;
	logic       toSt_r;
	logic       riseSt_r;
	logic       fallSt_r;
	logic       ptIrq_r;
	logic       toSet;
	logic       riseSet;
	logic       fallSet;
	logic       ptDone;

	wire demod   = ctlA_r[timer_pkg::CA_DEMOD];
	wire initOut = ctlA_r[timer_pkg::CA_INIT];
	wire ptEn    = ctlB_r[timer_pkg::CB_EN];
	wire ptStart = wrBase && wrData[timer_pkg::CB_EN] && !ptEn;
	wire ptStop  = !ptEn;
	wire hitRise = pinRise && ctlA_r[timer_pkg::CA_RISE_EN];
	wire hitFall = pinFall && ctlA_r[timer_pkg::CA_FALL_EN];
	wire hitEdge = hitRise || hitFall;
	wire [7:0] startLoad = initOut ? highLoad_r : lowLoad_r;

	always_comb begin
		state_nxt = state_r;
		ptCnt_nxt = ptCnt_r;
		ptOut_nxt = ptOut_r;
		toSet     = 1'b0;
		riseSet   = 1'b0;
		fallSet   = 1'b0;
		ptDone    = 1'b0;
		unique case (state_r)
			timer_pkg::PT_IDLE, timer_pkg::PT_DONE: begin
				if (state_r == timer_pkg::PT_IDLE)
					ptOut_nxt = ~initOut;
				if (ptStart && demod) begin
					state_nxt = timer_pkg::PT_WAIT;
				end else if (ptStart) begin
					state_nxt = timer_pkg::PT_TX;
					ptOut_nxt = initOut;
					ptCnt_nxt = startLoad;
				end
			end
			timer_pkg::PT_TX: begin
				if (ptStop) begin
					state_nxt = timer_pkg::PT_IDLE;
				end else if (baseTick && ptCnt_r == 8'h00) begin
					ptOut_nxt = ~ptOut_r;
					if (ctlB_r[timer_pkg::CB_MODN]) begin
						ptCnt_nxt = ptOut_r ? lowLoad_r : highLoad_r;
					end else begin
						toSet     = 1'b1;
						ptDone    = 1'b1;
						state_nxt = timer_pkg::PT_DONE;
					end
				end else if (baseTick) begin
					ptCnt_nxt = ptCnt_r - 8'h01;
				end
			end
			timer_pkg::PT_WAIT: begin
				if (ptStop) begin
					state_nxt = timer_pkg::PT_IDLE;
				end else if (hitEdge) begin
					state_nxt = timer_pkg::PT_COUNT;
					ptCnt_nxt = highLoad_r;
				end
			end
			timer_pkg::PT_COUNT: begin
				if (ptStop) begin
					state_nxt = timer_pkg::PT_IDLE;
				end else if (hitEdge) begin
					riseSet   = hitRise;
					fallSet   = hitFall;
					ptCnt_nxt = highLoad_r;
				end else if (baseTick && ptCnt_r == 8'h00) begin
					toSet     = 1'b1;
					ptCnt_nxt = timer_pkg::ALL_ONES;
				end else if (baseTick) begin
					ptCnt_nxt = ptCnt_r - 8'h01;
				end
			end
			default: begin
				state_nxt = timer_pkg::PT_IDLE;
			end
		endcase
	end

	// status flags: a hardware set wins over a same-cycle write-one clear
	wire toClr   = wrBase && wrData[timer_pkg::CB_TO_ST];
	wire riseClr = wrCtlA && demod && wrData[timer_pkg::CA_RISE_ST];
	wire fallClr = wrCtlA && demod && wrData[timer_pkg::CA_FALL_ST];
	wire irqReq  = (toSet && ctlB_r[timer_pkg::CB_TO_IE]) ||
		((riseSet || fallSet) && ctlB_r[timer_pkg::CB_EDGE_IE]);

	// stop lands only after the write; that same write can also clear status through bit 5
	wire [7:0] ctlB_nxt = wrBase ? wrData : ptDone ? (ctlB_r & ~(8'h01 << timer_pkg::CB_EN)) : ctlB_r;

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			ctlA_r     <= timer_pkg::RESET_BYTE;
			ctlB_r     <= timer_pkg::RESET_BYTE;
			lowLoad_r  <= timer_pkg::RESET_BYTE;
			highLoad_r <= timer_pkg::RESET_BYTE;
		end else begin
			if (wrCtlA)
				ctlA_r <= wrData;
			ctlB_r <= ctlB_nxt;
			if (wrLow)
				lowLoad_r <= wrData;
			if (wrHigh)
				highLoad_r <= wrData;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			state_r   <= timer_pkg::PT_IDLE;
			ptCnt_r   <= timer_pkg::RESET_BYTE;
			ptOut_r   <= 1'b1;
			riseCap_r <= timer_pkg::RESET_BYTE;
			fallCap_r <= timer_pkg::RESET_BYTE;
			ptIrq_r   <= 1'b0;
		end else begin
			state_r <= state_nxt;
			ptCnt_r <= ptCnt_nxt;
			ptOut_r <= ptOut_nxt;
			if (riseSet)
				riseCap_r <= ~ptCnt_r;
			if (fallSet)
				fallCap_r <= ~ptCnt_r;
			ptIrq_r <= irqReq;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			toSt_r   <= 1'b0;
			riseSt_r <= 1'b0;
			fallSt_r <= 1'b0;
		end else begin
			toSt_r   <= toSet || (toSt_r && !toClr);
			riseSt_r <= riseSet || (riseSt_r && !riseClr);
			fallSt_r <= fallSet || (fallSt_r && !fallClr);
		end
	end

	// ---------------- read port ----------------
	logic [7:0] rdData_r;
	logic [7:0] rdMux;

	wire [7:0] modeRead = {modeSel_r, 2'h0, genEnable_r, 1'b0, timer_pkg::MODE_RSVD_READ};
	wire [7:0] ctlARead = demod ? {ctlA_r[7:2], riseSt_r, fallSt_r} : ctlA_r;
	wire [7:0] ctlBRead = {ctlB_r[7:6], toSt_r, ctlB_r[4:0]};

	always_comb begin
		unique case (addr)
			timer_pkg::OFF_MODE:     rdMux = modeRead;
			timer_pkg::OFF_COUNT:    rdMux = genCnt_r;
			timer_pkg::OFF_PRESCALE: rdMux = prescale_r;
			timer_pkg::OFF_CTL_BASE: rdMux = ctlBRead;
			timer_pkg::OFF_CTL_A:    rdMux = ctlARead;
			timer_pkg::OFF_LOW:      rdMux = lowLoad_r;
			timer_pkg::OFF_HIGH:     rdMux = highLoad_r;
			timer_pkg::OFF_RISE:     rdMux = riseCap_r;
			timer_pkg::OFF_FALL:     rdMux = fallCap_r;
			default:                 rdMux = timer_pkg::RESET_BYTE;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!rstn)
			rdData_r <= timer_pkg::RESET_BYTE;
		else
			rdData_r <= rdEn ? rdMux : timer_pkg::RESET_BYTE;
	end

	assign rdData           = rdData_r;
	assign port5Bit6Pin     = pin_r;
	assign pulseTimerOutput = ptOut_r;
	assign generalTimerIrq  = genIrq_r;
	assign pulseTimerIrq    = ptIrq_r;

	// ---------------- checks ----------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);

	sequence txStart;
		state_r == timer_pkg::PT_IDLE && ptStart && !demod;
	endsequence

	sequence txLoaded;
		ptOut_r == $past(initOut) && ptCnt_r == $past(startLoad);
	endsequence

	a_load_forces_high: assert property (loadPulse |=> toggle_r)
		else $error("load did not force toggle output high");

	a_eoc_toggles: assert property (genEoc && !loadPulse |=> toggle_r != $past(toggle_r))
		else $error("toggle output missed end-of-count");

	a_eoc_irq_pin: assert property (genEoc && modeSel_r == timer_pkg::TOUT_SEL_GEN
		&& !wrMode |=> generalTimerIrq ##1 port5Bit6Pin == toggle_r)
		else $error("end-of-count not seen on irq and pin");

	a_single_stops: assert property (genEoc && !contMode && !wrMode |=> !genEnable_r)
		else $error("single pass did not stop");

	a_cont_reload: assert property (genEoc && contMode && !loadPulse |=> genCnt_r == $past(initVal_r))
		else $error("continuous reload wrong");

	a_pre_divide: assert property (preTick && !loadPulse |=> preCnt_r == $past(modulo))
		else $error("prescaler reload wrong");

	a_idle_inverse: assert property (state_r == timer_pkg::PT_IDLE && !ptStart
		|=> ptOut_r == !$past(initOut))
		else $error("idle pulse output not inverse of initial bit");

	a_tx_start: assert property (txStart |=> txLoaded)
		else $error("transmit start loaded wrong value");

	a_single_timeout: assert property (ptDone |=> toSt_r && !ptEn
		&& ptOut_r != $past(ptOut_r) && state_r == timer_pkg::PT_DONE)
		else $error("single pass transmit end wrong");

	a_capture_rise: assert property (state_r == timer_pkg::PT_COUNT && ptEn && hitRise
		|=> riseCap_r == ~$past(ptCnt_r) && riseSt_r && ptCnt_r == $past(highLoad_r))
		else $error("rising capture wrong");

	a_demod_wrap: assert property (state_r == timer_pkg::PT_COUNT && ptEn && !hitEdge
		&& baseTick && ptCnt_r == 8'h00 |=> ptCnt_r == 8'hff && toSt_r)
		else $error("demodulation wrap wrong");

endmodule : pulse_timer_block

`default_nettype wire

// File: verification/pin_source.sv
`timescale 1ns/1ns
`default_nettype none

// square waves on the timer pins; idle low when stopped, as an undriven pin would be pulled
module pin_source #(
	parameter int PULSE_HALF = 40,
	parameter int TIMER_HALF = 10
) (
	// clock
	input  wire logic ref_clk,
	// controls from the bench
	input  wire logic runPulse,
	input  wire logic runTimer,
	// pins
	output logic      pulseInPin,
	output logic      timerInPin
);
	int pulseCnt = 0;
	int timerCnt = 0;

	initial begin
		pulseInPin = 1'b0;
		timerInPin = 1'b0;
	end

	always @(posedge ref_clk) begin
		pulseCnt <= (!runPulse || pulseCnt == PULSE_HALF - 1) ? 0 : pulseCnt + 1;
		timerCnt <= (!runTimer || timerCnt == TIMER_HALF - 1) ? 0 : timerCnt + 1;
		if (!runPulse) pulseInPin <= 1'b0;
		else if (pulseCnt == PULSE_HALF - 1) pulseInPin <= !pulseInPin;
		if (!runTimer) timerInPin <= 1'b0;
		else if (timerCnt == TIMER_HALF - 1) timerInPin <= !timerInPin;
	end
endmodule : pin_source

`default_nettype wire

// File: verification/prescaled_timer_and_pulse_timer_tb.sv
`timescale 1ns/1ns
`default_nettype none

module prescaled_timer_and_pulse_timer_tb;
	logic       ref_clk = 1'b0;
	logic       rstn = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wrData = 8'h00;
	logic       wrEn = 1'b0;
	logic       rdEn = 1'b0;
	logic [7:0] rdData;
	logic       timerInPin;
	logic       pulseInPin;
	logic       port5DataBit = 1'b0;
	logic       port5Bit6Pin;
	logic       pulseTimerOutput;
	logic       generalTimerIrq;
	logic       pulseTimerIrq;
	logic       runPulse = 1'b0;
	logic       runTimer = 1'b0;
	logic [7:0] d;
	int         n;
	int         nMismatch = 0;
	int         nTests = 0;

	always #20 ref_clk = !ref_clk;

	pulse_timer_block dut_u (
		.ref_clk(ref_clk), .rstn(rstn), .addr(addr), .wrData(wrData), .wrEn(wrEn),
		.rdEn(rdEn), .rdData(rdData), .timerInPin(timerInPin), .pulseInPin(pulseInPin),
		.port5DataBit(port5DataBit), .port5Bit6Pin(port5Bit6Pin),
		.pulseTimerOutput(pulseTimerOutput), .generalTimerIrq(generalTimerIrq),
		.pulseTimerIrq(pulseTimerIrq)
	);

	pin_source src_u (
		.ref_clk(ref_clk), .runPulse(runPulse), .runTimer(runTimer),
		.pulseInPin(pulseInPin), .timerInPin(timerInPin)
	);

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		nTests++;
		if (seen !== exp) begin
			nMismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge ref_clk);
		addr <= a;
		wrData <= v;
		wrEn <= 1'b1;
		@(posedge ref_clk);
		wrEn <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge ref_clk);
		addr <= a;
		rdEn <= 1'b1;
		@(posedge ref_clk);
		rdEn <= 1'b0;
		#1 v = rdData;
	endtask : rd

	task automatic idle(input int c);
		repeat (c) @(posedge ref_clk);
		#1;
	endtask : idle

	// cycles until an event: 0 general irq, 1 pulse irq, 2 pulse output change
	task automatic waitEv(input int sel, input int limit, output int cnt);
		logic last;
		last = pulseTimerOutput;
		cnt = 0;
		do begin
			@(posedge ref_clk);
			#1 cnt++;
		end while (cnt < limit && !((sel == 0 && generalTimerIrq === 1'b1) ||
			(sel == 1 && pulseTimerIrq === 1'b1) || (sel == 2 && pulseTimerOutput !== last)));
	endtask : waitEv

	task automatic t_reset;
		rd(timer_pkg::OFF_MODE, d);
		check("mode reset", d, 8'h03);
		rd(timer_pkg::OFF_PRESCALE, d);
		check("prescale reset", d, 8'h00);
		rd(8'h10, d);
		check("unmapped read", d, 8'h00);
		check("pulse out reset", pulseTimerOutput, 1'b1);
		$display("test reset done");
	endtask : t_reset

	task automatic t_general;
		wr(timer_pkg::OFF_PRESCALE, 8'h0b);
		wr(timer_pkg::OFF_COUNT, 8'h03);
		wr(timer_pkg::OFF_MODE, 8'h8c);
		idle(3);
		check("toggle after load", port5Bit6Pin, 1'b1);
		rd(timer_pkg::OFF_MODE, d);
		check("mode readback", d, 8'h8b);
		waitEv(0, 200, n);
		idle(3);
		check("toggle after eoc", port5Bit6Pin, 1'b0);
		waitEv(0, 200, n);
		waitEv(0, 200, n);
		check("interval 2x3", 16'(n), 16'h0030);
		// a count written mid-run waits for the running end-of-count
		wr(timer_pkg::OFF_COUNT, 8'h01);
		waitEv(0, 200, n);
		check("count kept to eoc", 16'(n), 16'h002e);
		waitEv(0, 200, n);
		check("interval 2x1", 16'(n), 16'h0010);
		wr(timer_pkg::OFF_MODE, 8'h80);
		waitEv(0, 100, n);
		check("stopped", 16'(n), 16'h0064);
		// initial-count writes show on the live count only after a load or reload
		wr(timer_pkg::OFF_COUNT, 8'h09);
		rd(timer_pkg::OFF_COUNT, d);
		check("live count", d, 8'h01);
		port5DataBit <= 1'b1;
		wr(timer_pkg::OFF_MODE, 8'h00);
		idle(2);
		check("port data 1", port5Bit6Pin, 1'b1);
		port5DataBit <= 1'b0;
		idle(3);
		check("port data 0", port5Bit6Pin, 1'b0);
		$display("test general done");
	endtask : t_general

	task automatic t_modes;
		wr(timer_pkg::OFF_PRESCALE, 8'h07);
		wr(timer_pkg::OFF_COUNT, 8'h00);
		wr(timer_pkg::OFF_MODE, 8'h0c);
		waitEv(0, 3000, n);
		waitEv(0, 3000, n);
		check("count zero 256", 16'(n), 16'h0800);
		wr(timer_pkg::OFF_PRESCALE, 8'h06);
		wr(timer_pkg::OFF_COUNT, 8'h02);
		wr(timer_pkg::OFF_MODE, 8'h0c);
		waitEv(0, 200, n);
		check("single pass eoc", 16'(n < 200), 16'h0001);
		waitEv(0, 200, n);
		check("single pass stop", 16'(n), 16'h00c8);
		runTimer <= 1'b1;
		wr(timer_pkg::OFF_PRESCALE, 8'h05);
		wr(timer_pkg::OFF_MODE, 8'h0c);
		waitEv(0, 300, n);
		waitEv(0, 300, n);
		check("external clock", 16'(n), 16'h0028);
		runTimer <= 1'b0;
		wr(timer_pkg::OFF_MODE, 8'h00);
		$display("test modes done");
	endtask : t_modes

	task automatic t_transmit;
		wr(timer_pkg::OFF_LOW, 8'h03);
		wr(timer_pkg::OFF_HIGH, 8'h05);
		wr(timer_pkg::OFF_CTL_A, 8'h02);
		idle(2);
		check("idle inverse 1", pulseTimerOutput, 1'b0);
		wr(timer_pkg::OFF_CTL_A, 8'h00);
		idle(2);
		check("idle inverse 0", pulseTimerOutput, 1'b1);
		wr(timer_pkg::OFF_CTL_BASE, 8'hc0);
		idle(1);
		check("enable initial", pulseTimerOutput, 1'b0);
		waitEv(2, 200, n);
		waitEv(2, 200, n);
		check("high phase", 16'(n), 16'h0030);
		waitEv(2, 200, n);
		check("low phase", 16'(n), 16'h0020);
		wr(timer_pkg::OFF_CTL_BASE, 8'h00);
		wr(timer_pkg::OFF_LOW, 8'h02);
		wr(timer_pkg::OFF_CTL_A, 8'h02);
		wr(timer_pkg::OFF_CTL_BASE, 8'h82);
		idle(1);
		check("single initial", pulseTimerOutput, 1'b1);
		waitEv(1, 200, n);
		// six ticks from the high load; the low load would end near twenty cycles
		check("timeout irq high load", 16'(n >= 40 && n <= 47), 16'h0001);
		idle(1);
		check("single toggled", pulseTimerOutput, 1'b0);
		rd(timer_pkg::OFF_CTL_BASE, d);
		check("single status", d & 8'ha0, 8'h20);
		// stop and clear as two writes
		wr(timer_pkg::OFF_CTL_BASE, 8'h00);
		wr(timer_pkg::OFF_CTL_BASE, 8'h20);
		rd(timer_pkg::OFF_CTL_BASE, d);
		check("status cleared", d & 8'h20, 8'h00);
		$display("test transmit done");
	endtask : t_transmit

	task automatic t_demod;
		wr(timer_pkg::OFF_LOW, 8'hff);
		wr(timer_pkg::OFF_HIGH, 8'hff);
		wr(timer_pkg::OFF_CTL_A, 8'h90);
		wr(timer_pkg::OFF_CTL_BASE, 8'h84);
		runPulse <= 1'b1;
		waitEv(1, 300, n);
		waitEv(1, 300, n);
		check("edge irq spacing", 16'(n), 16'h0050);
		rd(timer_pkg::OFF_RISE, d);
		check("rise capture", 16'(d >= 8'h09 && d <= 8'h0b), 16'h0001);
		rd(timer_pkg::OFF_CTL_A, d);
		check("rise status", d & 8'h03, 8'h02);
		runPulse <= 1'b0;
		idle(2200);
		rd(timer_pkg::OFF_CTL_BASE, d);
		check("demod timeout", d & 8'ha0, 8'ha0);
		// falling edges only; the write also clears the rise status
		wr(timer_pkg::OFF_CTL_A, 8'ha2);
		runPulse <= 1'b1;
		waitEv(1, 300, n);
		waitEv(1, 300, n);
		check("fall edge spacing", 16'(n), 16'h0050);
		rd(timer_pkg::OFF_FALL, d);
		check("fall capture", 16'(d >= 8'h09 && d <= 8'h0b), 16'h0001);
		rd(timer_pkg::OFF_CTL_A, d);
		check("fall status", d & 8'h03, 8'h01);
		runPulse <= 1'b0;
		$display("test demod done");
	endtask : t_demod

	task automatic conclude;
		$display("comparisons %0d mismatches %0d", nTests, nMismatch);
		if (nMismatch == 0 && nTests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : conclude

	// run is about 7500 cycles; allow well over three times that
	initial begin
		repeat (30000) @(posedge ref_clk);
		nMismatch++;
		$display("watchdog expired");
		conclude();
	end

	initial begin
		repeat (2) @(posedge ref_clk);
		rstn <= 1'b1;
		t_reset();
		t_general();
		t_modes();
		t_transmit();
		t_demod();
		conclude();
	end
endmodule : prescaled_timer_and_pulse_timer_tb

`default_nettype wire
